// >>> core/gain_loader_defines.svh
`ifndef GAIN_LOADER_DEFINES_SVH
`define GAIN_LOADER_DEFINES_SVH

// width of the gain word
`define GAIN_WIDTH 8
// gain code after reset: lowest gain
`define GAIN_RESET 8'h00
// shift count after a complete word
`define GAIN_COUNT_FULL 4'h8
// shift count at the start of a word
`define COUNT_EMPTY 4'h0
// synchroniser reset: every pin but the serial clock (reset high) at its idle level (sleep off, transmit off)
`define SYNC_RESET 5'h17
// synchroniser bit positions of the pins
`define PIN_SCLK 0
`define PIN_SERIAL_GAIN_IN 1
`define PIN_WINDOW 2
`define PIN_TX 3
`define PIN_SLEEP 4

`endif

// >>> core/gain_loader_pkg.sv
package gain_loader_pkg;

    // operating mode shown to the analog side
    typedef enum logic [1:0] {MODE_SLEEP, MODE_TX_OFF, MODE_TX_ON} drive_mode_t;

endpackage

// >>> core/serial_gain_word_loader.sv
`timescale 1ns/1ps
`include "gain_loader_defines.svh"

// How it works
// - eight-bit word, one bit per clock, MSB first
// - rising edge captures master, falling edge moves slave
// - transmit input low disables, high enables
// - sleep input low sleeps, high normal
// - load window rise copies word, blocks shifting
// - load window fall holds gain, opens shifting
// - clock edges ignored until load window falls
// - each gain code bit adds coarse step
module serial_gain_word_loader
(
    input wire logic clk, // system clock, 125 MHz
    input wire logic rst_b, // asynchronous reset, active low
    input wire logic serial_clk, // serial clock from host
    input wire logic serial_gain_in, // serial gain data from host
    input wire logic load_window_n, // load window, active low
    input wire logic transmit_on, // transmit enable level
    input wire logic sleep_n, // sleep request, active low
    output logic [7:0] gain_code, // gain code applied to attenuator core
    output logic tx_enabled, // transmission enabled
    output logic sleep_active, // low power sleep in effect
    output gain_loader_pkg::drive_mode_t drive_mode // combined drive mode
);

    // first and second synchroniser stages for the pins
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    // previous synchronised serial clock and load window
    logic sclk_prev_reg;
    logic win_prev_reg;
    // shift register stages
    logic [7:0] master_reg; // shift chain, advanced on rising edges
    logic [7:0] slave_reg; // copy taken on falling edges
    // shifting allowed only inside an open window
    logic shift_open_reg;
    // bits shifted in the current window, held at eight once a full word is in
    logic [3:0] count_reg;

    // synchronised views
    logic sclk_s;
    logic serial_gain_in_s;
    logic win_s;
    logic sclk_rise;
    logic sclk_fall;
    logic win_rise;
    logic win_fall;

    // pin views come from the second stage only; edges compare against last cycle
    assign sclk_s = sync2_reg[`PIN_SCLK];
    assign serial_gain_in_s = sync2_reg[`PIN_SERIAL_GAIN_IN];
    assign win_s = sync2_reg[`PIN_WINDOW];
    assign sclk_rise = sclk_s && !sclk_prev_reg;
    assign sclk_fall = !sclk_s && sclk_prev_reg;
    assign win_rise = win_s && !win_prev_reg;
    assign win_fall = !win_s && win_prev_reg;

    // two-stage synchroniser for every pin input
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_reg <= `SYNC_RESET; // idle levels, so no false sleep after reset
            sync2_reg <= `SYNC_RESET;
        end
        else
        begin
            sync1_reg <= {sleep_n, transmit_on, load_window_n, serial_gain_in, serial_clk};
            sync2_reg <= sync1_reg;
        end
    end

    // edge history
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_prev_reg <= 1'h0;
            win_prev_reg <= 1'h1;
        end
        else
        begin
            sclk_prev_reg <= sclk_s;
            win_prev_reg <= win_s;
        end
    end

    // window gate: opened by a fall, closed by a rise
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            shift_open_reg <= 1'h0; // closed until first fall
        else if (win_fall)
            shift_open_reg <= 1'h1;
        else if (win_rise)
            shift_open_reg <= 1'h0;
    end

    // master stage: capture data on rising serial clock, MSB first
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            master_reg <= `GAIN_RESET;
            count_reg <= `COUNT_EMPTY;
        end
        else if (win_fall)
            count_reg <= `COUNT_EMPTY; // new word begins
        else if (shift_open_reg && sclk_rise)
        begin
            // earlier bits move toward bit 7
            master_reg <= {slave_reg[6:0], serial_gain_in_s};
            if (count_reg != `GAIN_COUNT_FULL)
                count_reg <= count_reg + 4'h1;
        end
    end

    // slave stage: follow the master on falling serial clock
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            slave_reg <= `GAIN_RESET;
        else if (shift_open_reg && sclk_fall)
            slave_reg <= master_reg;
    end

    // gain latch: load on window rise, hold otherwise
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            gain_code <= `GAIN_RESET; // lowest gain
        else if (win_rise && shift_open_reg)
            gain_code <= master_reg; // each set bit adds a step
    end

    // mode outputs from synchronised levels
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_enabled <= 1'h0;
            sleep_active <= 1'h0;
            drive_mode <= gain_loader_pkg::MODE_TX_OFF;
        end
        else
        begin
            tx_enabled <= sync2_reg[`PIN_TX];
            sleep_active <= !sync2_reg[`PIN_SLEEP];
            // sleep outranks transmit in the combined mode
            if (!sync2_reg[`PIN_SLEEP])
                drive_mode <= gain_loader_pkg::MODE_SLEEP;
            else if (sync2_reg[`PIN_TX])
                drive_mode <= gain_loader_pkg::MODE_TX_ON;
            else
                drive_mode <= gain_loader_pkg::MODE_TX_OFF;
        end
    end

    // gain only changes on a window rise
    gain_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(win_rise) |-> $stable(gain_code))
        else $error("gain changed outside load");
    // the shifted word reaches the core on the rise
    gain_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        (win_rise && shift_open_reg) |=> gain_code == $past(master_reg))
        else $error("gain not loaded on window rise");
    // a closed window freezes the shift chain
    shift_block_a: assert property (@(posedge clk) disable iff (!rst_b)
        !shift_open_reg |=> $stable(master_reg))
        else $error("shift while window closed");
    // new bit enters at bit 0, older bits move up toward the msb
    shift_msb_a: assert property (@(posedge clk) disable iff (!rst_b)
        (shift_open_reg && sclk_rise && !win_fall)
        |=> master_reg[0] == $past(serial_gain_in_s) && master_reg[7:1] == $past(slave_reg[6:0]))
        else $error("bad shift");
    // slave copies the master on a falling serial clock
    slave_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        (shift_open_reg && sclk_fall) |=> slave_reg == $past(master_reg))
        else $error("slave not updated");
    // transmit level shows after the synchroniser delay
    tx_level_a: assert property (@(posedge clk) disable iff (!rst_b)
        transmit_on [*4] |-> ##1 tx_enabled)
        else $error("transmit not enabled");
    tx_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        !transmit_on [*4] |-> ##1 !tx_enabled)
        else $error("transmit not disabled");
    // sleep level shows after the synchroniser delay
    sleep_level_a: assert property (@(posedge clk) disable iff (!rst_b)
        !sleep_n [*4] |-> ##1 sleep_active)
        else $error("sleep not entered");
    sleep_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
        sleep_n [*4] |-> ##1 !sleep_active)
        else $error("sleep not left");
    // window rise closes shifting, window fall opens it
    window_close_a: assert property (@(posedge clk) disable iff (!rst_b)
        win_rise |=> !shift_open_reg)
        else $error("window stayed open");
    window_open_a: assert property (@(posedge clk) disable iff (!rst_b)
        win_fall |=> shift_open_reg)
        else $error("window did not open");
    // opening a window keeps the old gain
    gain_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
        win_fall |=> $stable(gain_code))
        else $error("gain changed as window opened");

    // a full word loaded into the core
    load_seen_c: cover property (@(posedge clk) disable iff (!rst_b)
        win_rise && shift_open_reg && count_reg == `GAIN_COUNT_FULL);
    // a bit shifted inside an open window
    shift_seen_c: cover property (@(posedge clk) disable iff (!rst_b)
        shift_open_reg && sclk_rise);
    // serial clock ignored while the window is closed
    ignored_clk_c: cover property (@(posedge clk) disable iff (!rst_b)
        !shift_open_reg && sclk_rise);
    // sleep shown on the combined mode
    sleep_seen_c: cover property (@(posedge clk) disable iff (!rst_b)
        drive_mode == gain_loader_pkg::MODE_SLEEP);
    // transmit on with a gain above the lowest
    tx_gain_seen_c: cover property (@(posedge clk) disable iff (!rst_b)
        drive_mode == gain_loader_pkg::MODE_TX_ON && gain_code != `GAIN_RESET);

endmodule

// >>> testbench/gain_host.sv
`timescale 1ns/1ps

// host side of the serial gain link, driven by bench tasks
module gain_host
(
    input wire logic clk, // system clock, paces the serial lines
    output logic serial_clk, // serial clock, idle low outside frames
    output logic serial_gain_in, // serial data
    output logic load_window_n // load window, active low
);
    // idle levels at time zero
    initial
    begin
        serial_clk = 1'b0;
        serial_gain_in = 1'b1;
        load_window_n = 1'b1;
    end

    // one frame of n bits, msb first; open low keeps the window shut
    task automatic send(input logic [15:0] w, input int n, input logic open);
        @(posedge clk);
        load_window_n <= ~open;
        repeat (4) @(posedge clk);
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_gain_in <= w[i];
            serial_clk <= 1'b0;
            repeat (4) @(posedge clk);
            serial_clk <= 1'b1;
            repeat (4) @(posedge clk);
        end
        serial_clk <= 1'b0;
        serial_gain_in <= ~w[0]; // data no longer valid after hold
        repeat (4) @(posedge clk);
        load_window_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

// >>> testbench/serial_gain_word_loader_tb.sv
`timescale 1ns/1ps

module serial_gain_word_loader_tb;
    logic clk = 1'b0; // system clock
    logic rst_b = 1'b0; // reset, active low
    logic transmit_on = 1'b0; // transmit level
    logic sleep_n = 1'b1; // sleep level, active low
    logic serial_clk, serial_gain_in, load_window_n; // lines from host
    logic [7:0] gain_code, exp_gain; // seen and expected gain
    logic tx_enabled, sleep_active; // status levels
    gain_loader_pkg::drive_mode_t drive_mode; // combined mode
    int error_cnt = 0; // mismatches
    int samples_checked = 0; // comparisons
    int cycles = 0; // timeout counter

    serial_gain_word_loader serial_gain_word_loader_inst (.clk(clk), .rst_b(rst_b),
        .serial_clk(serial_clk), .serial_gain_in(serial_gain_in),
        .load_window_n(load_window_n), .transmit_on(transmit_on), .sleep_n(sleep_n),
        .gain_code(gain_code), .tx_enabled(tx_enabled), .sleep_active(sleep_active),
        .drive_mode(drive_mode));
    gain_host gain_host_inst (.clk(clk), .serial_clk(serial_clk),
        .serial_gain_in(serial_gain_in), .load_window_n(load_window_n));

    // 125 MHz clock
    initial
    begin
        forever #4 clk = ~clk;
    end

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic wrap_up;
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // expected mode: sleep wins over transmit
    function automatic logic [7:0] mode_of(input logic t, input logic s);
        return 8'(!s ? gain_loader_pkg::MODE_SLEEP :
            (t ? gain_loader_pkg::MODE_TX_ON : gain_loader_pkg::MODE_TX_OFF));
    endfunction

    // set control levels and check status
    task automatic levels(input logic t, input logic s);
        @(posedge clk);
        transmit_on <= t;
        sleep_n <= s;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check({7'h00, tx_enabled}, {7'h00, t});
        check({7'h00, sleep_active}, {7'h00, ~s});
        check(8'(drive_mode), mode_of(t, s));
    endtask

    // send a frame and check the loaded gain
    task automatic frame(input logic [15:0] w, input int n, input logic open);
        gain_host_inst.send(w, n, open);
        repeat (6) @(posedge clk);
        @(negedge clk);
        if (open)
            exp_gain = w[7:0];
        check(gain_code, exp_gain);
    endtask

    // cut a hang short
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    // main sequence
    initial
    begin
        void'($urandom(81278));
        exp_gain = 8'h00;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(gain_code, 8'h00);
        frame(16'h00A5, 8, 1'b0);
        frame(16'h00A5, 8, 1'b1);
        fork
            frame(16'h3C5A, 8, 1'b1);
            begin
                repeat (40) @(posedge clk);
                @(negedge clk);
                check(gain_code, 8'hA5);
            end
        join
        frame(16'h0381, 10, 1'b1);
        frame(16'h00FF, 8, 1'b0);
        for (int m = 0; m < 4; m++)
            levels(m[1], m[0]);
        for (int i = 0; i < 8; i++)
        begin
            frame({8'h00, 8'($urandom)}, 8, 1'b1);
            levels(1'($urandom), 1'($urandom));
        end
        wrap_up();
    end
endmodule
